// ### design/osw_ctrl.sv
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "osw_cfg.svh"

module osw_ctrl
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Configuration straps
  input  wire logic        fail_safe_config_bit,
  input  wire logic        one_way_pin_lock,
  input  wire logic [2:0]  reset_source_config,
  // Oscillator status pins
  input  wire logic [7:0]  src_ready,
  input  wire logic        pll_locked_in,
  input  wire logic        clock_fail_in,
  // Power state from the same clock domain
  input  wire logic        sleep_mode,
  // Clock tree controls
  output logic      [7:0]  clk_gate_en,
  output logic      [2:0]  cur_source,
  output logic             pll_enable,
  output logic             primary_osc_run,
  output logic             secondary_osc_run,
  output logic             pin_map_locked,
  output logic             irq
);

  // Sources that run through the PLL
  function automatic logic uses_pll(input logic [2:0] s);
    uses_pll = (s == osw_pkg::OSW_FAST_RC_PLL) || (s == osw_pkg::OSW_PRIMARY_PLL);
  endfunction

  // Sources that need the primary oscillator
  function automatic logic uses_primary(input logic [2:0] s);
    uses_primary = (s == osw_pkg::OSW_PRIMARY) || (s == osw_pkg::OSW_PRIMARY_PLL);
  endfunction

  // Two-flop synchronisers for pins; no reset so straps are seen during reset
  logic [14:0] pin_s1_r;
  logic [14:0] pin_s2_r;
  always_ff @(posedge ref_clk)
  begin
    pin_s1_r <= {fail_safe_config_bit, one_way_pin_lock, reset_source_config,
                 src_ready, pll_locked_in, clock_fail_in};
    pin_s2_r <= pin_s1_r;
  end

  wire       fail_safe_s = pin_s2_r[14];
  wire       one_way_s   = pin_s2_r[13];
  wire [2:0] strap_src_s = pin_s2_r[12:10];
  wire [7:0] ready_s     = pin_s2_r[9:2];
  wire       pll_lock_s  = pin_s2_r[1];
  wire       clk_fail_s  = pin_s2_r[0];

  // Register state
  osw_pkg::osw_src_t      new_src_r;
  logic                   clock_select_lock_r;
  logic                   pin_lock_r;
  logic                   fail_flag_r;
  logic                   pkeep_r;
  logic                   sec_en_r;
  logic                   sw_req_r;
  logic                   key_stage_r;
  logic                   unlock_r;
  logic [3:0]             unlock_cnt_r;
  logic                   fail_prev_r;
  logic                   fail_pend_r;
  logic [`OSW_IRQ_W-1:0]  stat_r;
  logic [`OSW_IRQ_W-1:0]  mask_r;

  // Sequencer handshake
  osw_pkg::osw_src_t      seq_cur;
  osw_pkg::osw_src_t      seq_target;
  logic                   seq_busy;
  logic                   seq_done;

  // Address decode
  wire wr_ctrl = reg_wr && (reg_addr == `OSW_IDX_CTRL);
  wire wr_key  = reg_wr && (reg_addr == `OSW_IDX_KEY);
  wire wr_stat = reg_wr && (reg_addr == `OSW_IDX_STAT);
  wire wr_mask = reg_wr && (reg_addr == `OSW_IDX_MASK);

  // Lock only bites when the fail-safe monitor is strapped on
  wire eff_lock  = fail_safe_s && clock_select_lock_r;
  wire sel_write = wr_ctrl && !eff_lock;

  // Pin lock may move only when unlocked and not held by the one-way strap
  wire pin_lock_hold = one_way_s && pin_lock_r;
  wire pin_lock_wr   = wr_ctrl && unlock_r && !pin_lock_hold;

  // A clock failure edge forces a switch to the fast RC oscillator
  wire fail_rise  = clk_fail_s && !fail_prev_r;
  wire seq_start  = !seq_busy && (fail_pend_r || sw_req_r);
  assign seq_target = fail_pend_r ? osw_pkg::OSW_FAST_RC : new_src_r;

  // PLL status is zero mid-switch or on a non-PLL source
  wire pll_stat = uses_pll(seq_cur) && pll_lock_s && !seq_busy;

  // Interrupt events
  wire [`OSW_IRQ_W-1:0] irq_evt = {clk_fail_s, seq_done};

  // Control word as software reads it
  wire [15:0] ctrl_rd = {5'h00,
                         new_src_r,
                         clock_select_lock_r,
                         pin_lock_r,
                         pll_stat,
                         1'b0,
                         fail_flag_r,
                         pkeep_r,
                         sec_en_r,
                         sw_req_r};

  wire [15:0] rd_mux =
    (reg_addr == `OSW_IDX_CTRL) ? ctrl_rd :
    (reg_addr == `OSW_IDX_STAT) ? {14'h0000, stat_r} :
    (reg_addr == `OSW_IDX_MASK) ? {14'h0000, mask_r} :
    16'h0000;

  // Selection and switch request
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      new_src_r <= osw_pkg::osw_src_t'(strap_src_s);
      clock_select_lock_r <= 1'b0;
      sw_req_r  <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        clock_select_lock_r <= reg_wdata[`OSW_CLOCK_SELECT_LOCK_BIT];
      if (sel_write)
        new_src_r <= osw_pkg::osw_src_t'(reg_wdata[`OSW_NSRC_HI:`OSW_NSRC_LO]);
      // Request stands until the sequencer finishes; a written zero cannot abort
      if (seq_done)
        sw_req_r <= 1'b0;
      else if (sel_write && reg_wdata[`OSW_SWREQ_BIT])
        sw_req_r <= 1'b1;
    end
  end

  // Sleep and secondary enables, pin-mapping lock
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pkeep_r    <= 1'b0;
      sec_en_r   <= 1'b0;
      pin_lock_r <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        pkeep_r  <= reg_wdata[`OSW_PKEEP_BIT];
        sec_en_r <= reg_wdata[`OSW_SEC_EN_BIT];
      end
      if (pin_lock_wr)
        pin_lock_r <= reg_wdata[`OSW_PINLOCK_BIT];
    end
  end

  // Unlock keys must arrive as two consecutive writes to the key register.
  // The unlock lasts for one control write or a short window, whichever first.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      key_stage_r  <= 1'b0;
      unlock_r     <= 1'b0;
      unlock_cnt_r <= 4'h0;
    end
    else
    begin
      if (reg_wr)
        key_stage_r <= wr_key && (reg_wdata == `OSW_KEY_FIRST);
      if (wr_key && key_stage_r && (reg_wdata == `OSW_KEY_SECOND))
      begin
        unlock_r     <= 1'b1;
        unlock_cnt_r <= 4'(`OSW_UNLOCK_CYC - 1);
      end
      else if (wr_ctrl || (unlock_cnt_r == 4'h0))
        unlock_r <= 1'b0;
      else
        unlock_cnt_r <= unlock_cnt_r - 4'h1;
    end
  end

  // Clock-fail flag: set wins over a software clear written as zero
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      fail_flag_r <= 1'b0;
      fail_prev_r <= 1'b0;
      fail_pend_r <= 1'b0;
    end
    else
    begin
      fail_prev_r <= clk_fail_s;
      if (clk_fail_s)
        fail_flag_r <= 1'b1;
      else if (wr_ctrl && !reg_wdata[`OSW_FAIL_BIT])
        fail_flag_r <= 1'b0;
      if (fail_rise)
        fail_pend_r <= 1'b1;
      else if (seq_start)
        fail_pend_r <= 1'b0;
    end
  end

  // Sticky interrupt status, write one to clear; a new event beats the clear
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      stat_r <= 2'h0;
      mask_r <= `OSW_MASK_RST;
    end
    else
    begin
      stat_r <= irq_evt | (stat_r & ~(wr_stat ? reg_wdata[1:0] : 2'h0));
      if (wr_mask)
        mask_r <= reg_wdata[1:0];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
  end

  // Registered oscillator controls
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pll_enable        <= 1'b0;
      primary_osc_run   <= 1'b0;
      secondary_osc_run <= 1'b0;
      pin_map_locked    <= 1'b0;
      irq               <= 1'b0;
    end
    else
    begin
      // PLL runs for the live source, and ahead of time for a PLL target
      pll_enable <= uses_pll(seq_cur) || (seq_busy && uses_pll(new_src_r));
      // Primary stops in sleep unless software asked to keep it
      primary_osc_run <= (uses_primary(seq_cur) || (seq_busy && uses_primary(new_src_r)))
                         && (!sleep_mode || pkeep_r);
      secondary_osc_run <= sec_en_r || (seq_cur == osw_pkg::OSW_SECONDARY);
      pin_map_locked    <= pin_lock_r;
      irq               <= |(stat_r & mask_r);
    end
  end

  assign cur_source = seq_cur;

  // Glitch-free changeover sequencer
  osw_switch_seq u_seq
  (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .start     (seq_start),
    .target    (seq_target),
    .reset_src (osw_pkg::osw_src_t'(strap_src_s)),
    .src_ready (ready_s),
    .cur_src   (seq_cur),
    .gate_en   (clk_gate_en),
    .busy      (seq_busy),
    .done      (seq_done)
  );

  clk_lock_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (wr_ctrl && fail_safe_s && clock_select_lock_r && !sw_req_r) |=> (!sw_req_r && $stable(new_src_r)))
    else $error("Locked selection changed by a write");

  no_lock_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (wr_ctrl && !fail_safe_s && reg_wdata[0] && !sw_req_r)
      |=> (sw_req_r && (new_src_r == $past(reg_wdata[10:8]))))
    else $error("Unlocked switch request was not taken");

  pin_guard_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (!unlock_r || !wr_ctrl) |=> $stable(pin_lock_r))
    else $error("Pin lock moved without unlock");

  one_way_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (one_way_s && pin_lock_r) |=> pin_lock_r)
    else $error("One-way pin lock was cleared");

  pll_stat_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (seq_busy || !uses_pll(seq_cur)) |-> !ctrl_rd[5])
    else $error("PLL status high during switch or without PLL");

  fail_flag_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_fail_s |=> (fail_flag_r ##1 fail_flag_r))
    else $error("Clock fail flag not held");

  sleep_stop_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (sleep_mode && !pkeep_r) |=> !primary_osc_run)
    else $error("Primary running in sleep");

  sec_enable_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    sec_en_r |=> secondary_osc_run)
    else $error("Secondary oscillator not enabled");

  sw_clear_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (sw_req_r && seq_done) |=> (!sw_req_r && (cur_source == $past(seq_cur))))
    else $error("Switch request not cleared at completion");

  rsvd_zero_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == `OSW_IDX_CTRL) |=> (reg_rdata[4] == 1'b0))
    else $error("Reserved control bit read as one");

endmodule // osw_ctrl

// ### design/osw_cfg.svh
// Operation
// - New-source codes 000, 001, 110, 111 pick the fast RC variants.
// - Codes 010, 011, 100, 101 pick primary, primary+PLL, secondary, low-power RC.
// - With fail-safe monitor on, the clock lock bit freezes source and PLL selection.
// - With fail-safe monitor off, selections are never locked.
// - Pin-mapping lock bit sits at bit 6; one means active.
// - Pin-mapping lock changes only after the unlock key sequence.
// - With one-way pin lock strapped, a set pin lock stays set until reset.
// - PLL lock status at bit 5 is one when the PLL is locked.
// - PLL lock status reads zero during a switch or without a PLL mode.
// - Clock-fail flag at bit 3 is set when the monitor sees a failure.
// - Bit 2 set keeps the primary oscillator running in sleep.
// - Bit 1 enables the 32 kHz secondary oscillator.
// - Software sets bit 0 to request a switch; hardware clears it when done.
// - Bit 4 of the control register always reads zero.
// - New-source field resets to the strapped reset source.
`ifndef OSW_CFG_SVH
`define OSW_CFG_SVH

// Register indices on the local port
`define OSW_IDX_CTRL      4'h0
`define OSW_IDX_KEY       4'h1
`define OSW_IDX_STAT      4'h2
`define OSW_IDX_MASK      4'h3

// Control register fields
`define OSW_NSRC_HI       10
`define OSW_NSRC_LO       8
`define OSW_CLOCK_SELECT_LOCK_BIT   7
`define OSW_PINLOCK_BIT   6
`define OSW_PLLSTAT_BIT   5
`define OSW_RSVD_BIT      4
`define OSW_FAIL_BIT      3
`define OSW_PKEEP_BIT     2
`define OSW_SEC_EN_BIT    1
`define OSW_SWREQ_BIT     0

// Interrupt status and mask fields
`define OSW_IRQ_W         2
`define OSW_IRQ_DONE_BIT  0
`define OSW_IRQ_FAIL_BIT  1
`define OSW_MASK_RST      2'h0

// Unlock keys, written back to back to the key register
`define OSW_KEY_FIRST     16'h0046
`define OSW_KEY_SECOND    16'h0057

// Timing
`define OSW_CLK_PERIOD_NS 4
`define OSW_SETTLE_NS     16
`define OSW_SETTLE_CYC    ((`OSW_SETTLE_NS + `OSW_CLK_PERIOD_NS - 1) / `OSW_CLK_PERIOD_NS)
`define OSW_UNLOCK_NS     32
`define OSW_UNLOCK_CYC    (`OSW_UNLOCK_NS / `OSW_CLK_PERIOD_NS)

`endif

// ### design/osw_pkg.sv
package osw_pkg;

  // Clock source codes of the new-source field
  typedef enum logic [2:0]
  {
    OSW_FAST_RC          = 3'h0,
    OSW_FAST_RC_PLL      = 3'h1,
    OSW_PRIMARY          = 3'h2,
    OSW_PRIMARY_PLL      = 3'h3,
    OSW_SECONDARY        = 3'h4,
    OSW_LOW_POWER_RC     = 3'h5,
    OSW_FAST_RC_DIV16    = 3'h6,
    OSW_FAST_RC_POSTSCL  = 3'h7
  } osw_src_t;

  // Switch sequencer states, Gray along the path from idle to done
  typedef enum logic [2:0]
  {
    OSW_ST_IDLE     = 3'h0,
    OSW_ST_WAIT_RDY = 3'h1,
    OSW_ST_GATE_OFF = 3'h3,
    OSW_ST_GATE_ON  = 3'h2,
    OSW_ST_DONE     = 3'h6
  } osw_state_t;

endpackage

// ### design/osw_switch_seq.sv
`timescale 1ns/1ns
`include "osw_cfg.svh"

module osw_switch_seq
(
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             start,
  input  osw_pkg::osw_src_t     target,
  input  osw_pkg::osw_src_t     reset_src,
  input  wire logic [7:0]       src_ready,
  output osw_pkg::osw_src_t     cur_src,
  output logic      [7:0]       gate_en,
  output logic                  busy,
  output logic                  done
);

  osw_pkg::osw_state_t state_r;
  osw_pkg::osw_src_t   tgt_r;
  logic [3:0]          settle_r;
  logic                gate_on_r;
  wire                 settled = (settle_r == 4'(`OSW_SETTLE_CYC - 1));

  assign busy = (state_r != osw_pkg::OSW_ST_IDLE);
  assign done = (state_r == osw_pkg::OSW_ST_DONE);

  // Break before make: all gates close and settle before the new one opens
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_r   <= osw_pkg::OSW_ST_IDLE;
      tgt_r     <= reset_src;
      cur_src   <= reset_src;
      settle_r  <= 4'h0;
      gate_on_r <= 1'b1;
    end
    else
    begin
      case (state_r)
        osw_pkg::OSW_ST_IDLE:
        begin
          if (start)
          begin
            tgt_r   <= target;
            state_r <= osw_pkg::OSW_ST_WAIT_RDY;
          end
        end
        osw_pkg::OSW_ST_WAIT_RDY:
        begin
          // Old clock keeps running until the new source reports ready
          if (src_ready[tgt_r])
          begin
            gate_on_r <= 1'b0;
            settle_r  <= 4'h0;
            state_r   <= osw_pkg::OSW_ST_GATE_OFF;
          end
        end
        osw_pkg::OSW_ST_GATE_OFF:
        begin
          settle_r <= settle_r + 4'h1;
          if (settled)
          begin
            cur_src <= tgt_r;
            state_r <= osw_pkg::OSW_ST_GATE_ON;
          end
        end
        osw_pkg::OSW_ST_GATE_ON:
        begin
          gate_on_r <= 1'b1;
          state_r   <= osw_pkg::OSW_ST_DONE;
        end
        default:
          state_r <= osw_pkg::OSW_ST_IDLE;
      endcase
    end
  end

  // One registered gate enable per source; never two open at once
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_gate
      always_ff @(posedge ref_clk)
      begin
        if (!rst_n)
          gate_en[gi] <= 1'b0;
        else
          gate_en[gi] <= gate_on_r && (cur_src == 3'(gi));
      end
    end
  endgenerate

  one_gate_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n) $onehot0(gate_en))
    else $error("Two clock gates open at once");

endmodule // osw_switch_seq

// ### sim/tb_oscillator_switch_control.sv
`timescale 1ns/1ns
`include "osw_cfg.svh"

module tb_oscillator_switch_control;
  typedef struct {logic [15:0] exp; logic [15:0] msk; string name;} osw_note_t;

  localparam logic [2:0] codes_c [8] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h4, 3'h6, 3'h7, 3'h5};

  logic        ref_clk              = 1'b0;
  logic        rst_n                = 1'b0;
  logic [3:0]  reg_addr             = 4'h0;
  logic [15:0] reg_wdata            = 16'h0;
  logic        reg_wr               = 1'b0;
  logic        reg_rd               = 1'b0;
  logic [15:0] reg_rdata;
  logic        fail_safe_config_bit = 1'b0;
  logic        one_way_pin_lock     = 1'b0;
  logic [2:0]  reset_source_config  = 3'h5;
  logic [7:0]  src_ready            = 8'hff;
  logic        pll_locked_in        = 1'b1;
  logic        clock_fail_in        = 1'b0;
  logic        sleep_mode           = 1'b0;
  logic [7:0]  clk_gate_en;
  logic [2:0]  cur_source;
  logic        pll_enable;
  logic        primary_osc_run;
  logic        secondary_osc_run;
  logic        pin_map_locked;
  logic        irq;
  logic        rd_q                 = 1'b0;
  logic [31:0] rnd                  = 32'h7429;
  osw_note_t   notes [$];
  int          num_errors           = 0;
  int          check_count          = 0;
  int          cycles               = 0;

  osw_ctrl uut
  (
    .ref_clk              (ref_clk),
    .rst_n                (rst_n),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .fail_safe_config_bit (fail_safe_config_bit),
    .one_way_pin_lock     (one_way_pin_lock),
    .reset_source_config  (reset_source_config),
    .src_ready            (src_ready),
    .pll_locked_in        (pll_locked_in),
    .clock_fail_in        (clock_fail_in),
    .sleep_mode           (sleep_mode),
    .clk_gate_en          (clk_gate_en),
    .cur_source           (cur_source),
    .pll_enable           (pll_enable),
    .primary_osc_run      (primary_osc_run),
    .secondary_osc_run    (secondary_osc_run),
    .pin_map_locked       (pin_map_locked),
    .irq                  (irq)
  );

  // Free running clock, 4 ns period
  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Control word: source, clock lock, pin lock, PLL status, bits 2:1, request
  function automatic logic [15:0] ctl(input logic [2:0] s, input logic lk, input logic pin,
                                      input logic pl, input logic [1:0] b21, input logic req);
    ctl = {5'h00, s, lk, pin, pl, 2'b00, b21, req};
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Every bus cycle sets both strobes, so writes may run back to back
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m,
                    input string name);
    notes.push_back('{e, m, name});
    bus(1'b0, 1'b1, a, 16'h0000);
  endtask

  // Control register read with every bit compared
  task automatic rdc(input logic [15:0] e, input string name);
    rd(`OSW_IDX_CTRL, e, 16'hffff, name);
  endtask

  task automatic idle(input int n);
    bus(1'b0, 1'b0, 4'h0, 16'h0000);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic unlock;
    wr(`OSW_IDX_KEY, `OSW_KEY_FIRST);
    wr(`OSW_IDX_KEY, `OSW_KEY_SECOND);
  endtask

  task automatic do_reset(input logic fs, input logic ow, input logic [2:0] s);
    fail_safe_config_bit <= fs;
    one_way_pin_lock <= ow;
    reset_source_config <= s;
    rst_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask

  // Waits for the changeover; the gates must never overlap and must all close once
  task automatic wait_sw(input logic [2:0] c);
    int   n;
    logic gap;
    logic multi;
    n = 0;
    gap = 1'b0;
    multi = 1'b0;
    idle(1);
    while (!(cur_source === c && clk_gate_en === (8'h01 << c)) && n < 300)
    begin
      if (clk_gate_en === 8'h00)
        gap = 1'b1;
      if ($countones(clk_gate_en) > 1)
        multi = 1'b1;
      n++;
      @(posedge ref_clk);
    end
    chk("source in use", {13'h0, cur_source}, {13'h0, c});
    chk("gate gap", {15'h0, gap}, 16'h0001);
    chk("gate overlap", {15'h0, multi}, 16'h0000);
    repeat (4) @(posedge ref_clk);
  endtask

  // Read data stands only in the cycle after the strobe; oldest note is compared there
  always @(posedge ref_clk)
  begin
    if (rd_q)
    begin
      osw_note_t nt;
      nt = notes.pop_front();
      chk(nt.name, reg_rdata & nt.msk, nt.exp);
    end
    rd_q <= reg_rd;
  end

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial
  begin
    logic [1:0] rb;
    logic       pl;
    logic [2:0] c;
    do_reset(1'b0, 1'b0, 3'h5);
    chk("reset source", {13'h0, cur_source}, 16'h0005);
    idle(3);
    rdc(16'h0500, "ctrl reset");
    rd(4'h7, 16'h0000, 16'hffff, "unmapped");
    idle(2);
    $display("test reset done");

    // Every source code, with random sleep and secondary bits riding along
    foreach (codes_c[i])
    begin
      c = codes_c[i];
      rnd = lfsr(rnd);
      rb = rnd[1:0];
      pl = (c == 3'h1) || (c == 3'h3);
      wr(`OSW_IDX_CTRL, ctl(c, 1'b0, 1'b0, 1'b0, rb, 1'b1));
      idle(2);
      rdc(ctl(c, 1'b0, 1'b0, 1'b0, rb, 1'b1), "ctrl busy");
      wait_sw(c);
      rdc(ctl(c, 1'b0, 1'b0, pl, rb, 1'b0), "ctrl done");
      chk("pll enable", {15'h0, pll_enable}, {15'h0, pl});
      chk("primary run", {15'h0, primary_osc_run}, {15'h0, c[2:1] == 2'b01});
    end
    $display("test source codes done");

    // Lock bit has no effect without the fail-safe monitor
    wr(`OSW_IDX_CTRL, ctl(3'h5, 1'b1, 1'b0, 1'b0, 2'b00, 1'b0));
    wr(`OSW_IDX_CTRL, ctl(3'h2, 1'b1, 1'b0, 1'b0, 2'b00, 1'b1));
    wait_sw(3'h2);
    $display("test lock ignored done");

    for (int k = 0; k < 2; k++)
    begin
      wr(`OSW_IDX_CTRL, ctl(3'h2, 1'b1, 1'b0, 1'b0, {k[0], k[0]}, 1'b0));
      sleep_mode <= 1'b1;
      idle(3);
      chk("primary in sleep", {15'h0, primary_osc_run}, {15'h0, k[0]});
      chk("secondary run", {15'h0, secondary_osc_run}, {15'h0, k[0]});
      sleep_mode <= 1'b0;
    end
    $display("test sleep done");

    wr(`OSW_IDX_CTRL, ctl(3'h2, 1'b1, 1'b1, 1'b0, 2'b00, 1'b0));
    rdc(ctl(3'h2, 1'b1, 1'b0, 1'b0, 2'b00, 1'b0), "pin guarded");
    unlock();
    wr(`OSW_IDX_CTRL, ctl(3'h2, 1'b1, 1'b1, 1'b0, 2'b00, 1'b0));
    rdc(ctl(3'h2, 1'b1, 1'b1, 1'b0, 2'b00, 1'b0), "pin set");
    idle(1);
    chk("pin lock out", {15'h0, pin_map_locked}, 16'h0001);
    unlock();
    wr(`OSW_IDX_CTRL, ctl(3'h2, 1'b1, 1'b0, 1'b0, 2'b00, 1'b0));
    rdc(ctl(3'h2, 1'b1, 1'b0, 1'b0, 2'b00, 1'b0), "pin cleared");
    idle(2);
    $display("test pin lock done");

    do_reset(1'b1, 1'b1, 3'h3);
    chk("reset source pll", {13'h0, cur_source}, 16'h0003);
    idle(3);
    rdc(16'h0320, "ctrl reset pll");
    // PLL out of lock: status drops although a PLL source is in use
    pll_locked_in <= 1'b0;
    idle(3);
    rdc(16'h0300, "pll unlocked");
    pll_locked_in <= 1'b1;
    idle(3);
    wr(`OSW_IDX_CTRL, ctl(3'h3, 1'b1, 1'b0, 1'b0, 2'b00, 1'b0));
    wr(`OSW_IDX_CTRL, ctl(3'h4, 1'b1, 1'b0, 1'b0, 2'b00, 1'b1));
    idle(20);
    chk("locked source", {13'h0, cur_source}, 16'h0003);
    rdc(ctl(3'h3, 1'b1, 1'b0, 1'b1, 2'b00, 1'b0), "ctrl locked");
    wr(`OSW_IDX_CTRL, ctl(3'h3, 1'b0, 1'b0, 1'b0, 2'b00, 1'b0));
    wr(`OSW_IDX_CTRL, ctl(3'h4, 1'b0, 1'b0, 1'b0, 2'b00, 1'b1));
    wait_sw(3'h4);
    $display("test clock lock done");

    unlock();
    wr(`OSW_IDX_CTRL, ctl(3'h4, 1'b0, 1'b1, 1'b0, 2'b00, 1'b0));
    unlock();
    wr(`OSW_IDX_CTRL, ctl(3'h4, 1'b0, 1'b0, 1'b0, 2'b00, 1'b0));
    rdc(ctl(3'h4, 1'b0, 1'b1, 1'b0, 2'b00, 1'b0), "pin one way");
    idle(1);
    chk("pin held", {15'h0, pin_map_locked}, 16'h0001);
    $display("test one way lock done");

    // Failure with the event masked, then unmasked, then cleared
    wr(`OSW_IDX_STAT, 16'h0003);
    wr(`OSW_IDX_MASK, 16'h0000);
    clock_fail_in <= 1'b1;
    wait_sw(3'h0);
    chk("irq masked", {15'h0, irq}, 16'h0000);
    rd(`OSW_IDX_STAT, 16'h0002, 16'h0002, "status fail");
    rd(`OSW_IDX_CTRL, 16'h0008, 16'h0018, "fail flag");
    wr(`OSW_IDX_MASK, 16'h0002);
    idle(3);
    chk("irq raised", {15'h0, irq}, 16'h0001);
    clock_fail_in <= 1'b0;
    idle(4);
    wr(`OSW_IDX_STAT, 16'h0003);
    wr(`OSW_IDX_CTRL, ctl(3'h0, 1'b0, 1'b1, 1'b0, 2'b00, 1'b0));
    idle(3);
    chk("irq cleared", {15'h0, irq}, 16'h0000);
    rd(`OSW_IDX_STAT, 16'h0000, 16'hffff, "status clear");
    rd(`OSW_IDX_CTRL, 16'h0000, 16'h0018, "fail clear");
    idle(3);
    $display("test clock fail done");
    tally_and_finish();
  end
endmodule // tb_oscillator_switch_control
